// ---- sbt_pkg.sv ----
// Package: constants and types for the SRAM boundary-scan test port
// Overview of operation
// RULE1 - Sixteen-state controller, self reset at power-up
// RULE2 - IR 3, bypass 1, ID 32, chain 109
// RULE3 - ID: revision, configuration, maker code, one
// RULE4 - Configuration field encodes density, width, options
// RULE5 - Decode EXTEST, IDCODE, SAMPLE-Z, SAMPLE, BYPASS codes
// RULE6 - Controller never loads reserved codes 011/101/110
// RULE7 - Output-off sampling floats Q, captures all inputs
// RULE8 - Plain sampling captures pins, Q not floated
// RULE9 - Bypass cleared on selection, keeps last bit
// RULE10 - External test floats Q unless control cell set
// RULE11 - Drive transfer happens at update-IR after load
// RULE12 - Control cell changes only in SAMPLE/EXTEST
// RULE13 - TDI enters first cell while shifting
// RULE14 - One chain order, unconnected cells don't care
// RULE15 - No multiplexer in functional pin path
// RULE16 - Sample on rising TCK, TDO on falling
// RULE17 - Limited subset, nonstandard external test
// RULE18 - Five TMS-high edges force reset state
// RULE19 - ID shifts out LSB first, one first
package sbt_pkg;
    // ------------------------------------------------------------
    // Register sizes
    // ------------------------------------------------------------
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_LEN = 109;
    localparam int PIN_W = 108;
    localparam int CTRL_POS = 108;
    localparam int Q_W = 36;
    localparam int Q_LSB = 0;
    localparam int FIFO_DEPTH = 32;
    localparam int TLR_TMS_EDGES = 5;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLEZ = 3'h2;
    localparam logic [2:0] IR_SAMPLE = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h1;
    localparam logic [2:0] IR_RESET = IR_IDCODE;

    // ------------------------------------------------------------
    // Identification word fields (maker and options arbitrary)
    // ------------------------------------------------------------
    localparam logic [2:0] ID_REV = 3'h0;
    localparam logic [2:0] ID_DENSITY = 3'h1;
    localparam logic [1:0] ID_WIDTH = 2'h1;
    localparam logic ID_DLL = 1'h0;
    localparam logic ID_ARCH = 1'h0;
    localparam logic ID_BURST = 1'h0;
    localparam logic ID_SEPIO = 1'h0;
    localparam logic [10:0] ID_MAKER = 11'h2A5;
    localparam logic ID_START = 1'h1;
    localparam logic [16:0] ID_CFG = {2'h0, ID_DENSITY, 1'h0, ID_WIDTH,
        1'h0, ID_DLL, 1'h0, ID_ARCH, 1'h0, ID_BURST, 1'h0, ID_SEPIO, 1'h0};
    localparam logic [31:0] ID_WORD = {ID_REV, ID_CFG, ID_MAKER, ID_START};

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } sbt_state_t;
endpackage

// ---- sbt_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sbt_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // Handshake terms, honest full and empty
    assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem[rd_ptr_reg];
    assign push = ce_i && in_valid_i && in_ready_o;
    assign pop = ce_i && out_valid_o && out_ready_i;

    // Storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= AW'(wr_ptr_reg + 1'h1);
            end
            if (pop) begin
                rd_ptr_reg <= AW'(rd_ptr_reg + 1'h1);
            end
            if (push && !pop) begin
                cnt_reg <= (AW+1)'(cnt_reg + 1'h1);
            end else if (pop && !push) begin
                cnt_reg <= (AW+1)'(cnt_reg - 1'h1);
            end
        end
    end
endmodule

// ---- sbt_tap.sv ----
// Boundary-scan test port of the SRAM with system-side drive stream
`timescale 1ns/1ps
module sbt_tap (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic [sbt_pkg::PIN_W-1:0] pin_i,
    output logic q_hiz_o,
    output logic [sbt_pkg::Q_W-1:0] q_test_o,
    output logic q_test_valid_o,
    input wire logic q_test_ready_i
);
    import sbt_pkg::*;

    // ------------------------------------------------------------
    // Test-clock domain
    // ------------------------------------------------------------
    logic rst_t1_reg, rst_t_n, ce_t1_reg, ce_t2_reg, en_t;
    logic [PIN_W-1:0] pin_t1_reg, pin_t2_reg;
    sbt_state_t state_reg, state_next;
    logic [IR_W-1:0] ir_sh_reg, ir_reg;
    logic [BSR_LEN-1:0] bsr_reg;
    logic [ID_W-1:0] id_sh_reg;
    logic byp_reg, ctrl_reg, hiz_t_reg, drv_en_reg, upd_tgl_reg, sel_bsr, dr_bit;
    logic [Q_W-1:0] drv_reg;

    // Reset release aligned to the test clock (power-up reset)
    always_ff @(posedge tck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_t1_reg <= 1'h0;
            rst_t_n <= 1'h0;
        end else begin
            rst_t1_reg <= 1'h1;
            rst_t_n <= rst_t1_reg; // RULE1
        end
    end

    // Clock enable brought into the test clock domain
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            ce_t1_reg <= 1'h0;
            ce_t2_reg <= 1'h0;
        end else begin
            ce_t1_reg <= ce_i;
            ce_t2_reg <= ce_t1_reg;
        end
    end
    assign en_t = ce_t2_reg;

    // Pin states synchronised before capture; functional path untouched
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            pin_t1_reg <= '0;
            pin_t2_reg <= '0;
        end else if (en_t) begin
            pin_t1_reg <= pin_i; // RULE15
            pin_t2_reg <= pin_t1_reg;
        end
    end

    // Controller next state from TMS
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_TLR: state_next = tms_i ? ST_TLR : ST_RTI;
            ST_RTI: state_next = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_next = tms_i ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_next = tms_i ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: state_next = tms_i ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_next = tms_i ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_next = tms_i ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_next = tms_i ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_next = tms_i ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_next = tms_i ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: state_next = tms_i ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: state_next = tms_i ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_next = tms_i ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_next = tms_i ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_next = tms_i ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_next = tms_i ? ST_SEL_DR : ST_RTI;
            default: state_next = ST_TLR;
        endcase
    end

    // Controller state, TMS taken on the rising test clock
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            state_reg <= ST_TLR; // RULE1
        end else if (en_t) begin
            state_reg <= state_next; // RULE16
        end
    end

    // Instruction shift and update; reserved codes act as bypass
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            ir_sh_reg <= IR_CAPTURE;
            ir_reg <= IR_RESET;
        end else if (en_t) begin
            case (state_reg)
                ST_TLR: ir_reg <= IR_RESET;
                ST_CAP_IR: ir_sh_reg <= IR_CAPTURE; // RULE2
                ST_SH_IR: ir_sh_reg <= {tdi_i, ir_sh_reg[IR_W-1:1]};
                ST_UPD_IR: ir_reg <= ir_sh_reg; // RULE5
                default: ir_reg <= ir_reg;
            endcase
        end
    end

    // Boundary chain selected by the three boundary instructions
    assign sel_bsr = (ir_reg == IR_EXTEST) || (ir_reg == IR_SAMPLEZ)
        || (ir_reg == IR_SAMPLE); // RULE5

    // Boundary chain: one order for both widths; cell 108 nearest TDI
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            bsr_reg <= '0;
        end else if (en_t && sel_bsr) begin
            if (state_reg == ST_CAP_DR) begin
                bsr_reg <= {ctrl_reg, pin_t2_reg}; // RULE7 RULE8 RULE14
            end else if (state_reg == ST_SH_DR) begin
                bsr_reg <= {tdi_i, bsr_reg[BSR_LEN-1:1]}; // RULE13
            end
        end
    end

    // Internal control cell, alterable under SAMPLE and EXTEST only
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            ctrl_reg <= 1'h0;
        end else if (en_t && state_reg == ST_UPD_DR
            && (ir_reg == IR_SAMPLE || ir_reg == IR_EXTEST)) begin
            ctrl_reg <= bsr_reg[CTRL_POS]; // RULE12
        end
    end

    // Identification register, least significant bit leaves first
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            id_sh_reg <= ID_WORD;
        end else if (en_t && ir_reg == IR_IDCODE) begin
            if (state_reg == ST_CAP_DR) begin
                id_sh_reg <= ID_WORD; // RULE3 RULE4
            end else if (state_reg == ST_SH_DR) begin
                id_sh_reg <= {tdi_i, id_sh_reg[ID_W-1:1]}; // RULE19
            end
        end
    end

    // Bypass cell: cleared on selection, keeps the last TDI bit
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            byp_reg <= 1'h0;
        end else if (en_t) begin
            if (state_reg == ST_UPD_IR && ir_sh_reg == IR_BYPASS) begin
                byp_reg <= 1'h0; // RULE9
            end else if (!sel_bsr && ir_reg != IR_IDCODE) begin
                if (state_reg == ST_CAP_DR) begin
                    byp_reg <= 1'h0;
                end else if (state_reg == ST_SH_DR) begin
                    byp_reg <= tdi_i; // RULE9
                end
            end
        end
    end

    // Output float level and drive transfer at update-IR
    always_ff @(posedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            hiz_t_reg <= 1'h0;
            drv_reg <= '0;
            drv_en_reg <= 1'h0;
            upd_tgl_reg <= 1'h0;
        end else if (en_t) begin
            if (state_reg == ST_TLR) begin
                hiz_t_reg <= 1'h0;
            end else if (state_reg == ST_UPD_IR) begin
                hiz_t_reg <= (ir_sh_reg == IR_SAMPLEZ) // RULE7 RULE8
                    || (ir_sh_reg == IR_EXTEST && !ctrl_reg); // RULE10 RULE17
                if (ir_sh_reg == IR_EXTEST) begin
                    drv_reg <= bsr_reg[Q_LSB +: Q_W]; // RULE11
                    drv_en_reg <= ctrl_reg; // RULE10
                    upd_tgl_reg <= ~upd_tgl_reg;
                end
            end
        end
    end

    // Serial data out of the selected register
    always_comb begin
        dr_bit = byp_reg;
        if (sel_bsr) begin
            dr_bit = bsr_reg[0];
        end else if (ir_reg == IR_IDCODE) begin
            dr_bit = id_sh_reg[0];
        end
    end

    // TDO changes after the falling test clock edge
    always_ff @(negedge tck_i or negedge rst_t_n) begin
        if (!rst_t_n) begin
            tdo_o <= 1'h0;
            tdo_oe_o <= 1'h0;
        end else if (en_t) begin
            tdo_oe_o <= (state_reg == ST_SH_DR) || (state_reg == ST_SH_IR);
            if (state_reg == ST_SH_IR) begin
                tdo_o <= ir_sh_reg[0]; // RULE16
            end else if (state_reg == ST_SH_DR) begin
                tdo_o <= dr_bit; // RULE16
            end
        end
    end

    // ------------------------------------------------------------
    // System-clock domain
    // ------------------------------------------------------------
    logic hiz_s1_reg, hiz_s2_reg, tgl_s1_reg, tgl_s2_reg, tgl_s3_reg, pend_reg;
    logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [Q_W-1:0] word_reg, fifo_out_data;

    // Float level and transfer toggle crossing from the test clock
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hiz_s1_reg <= 1'h0;
            hiz_s2_reg <= 1'h0;
            q_hiz_o <= 1'h0;
            tgl_s1_reg <= 1'h0;
            tgl_s2_reg <= 1'h0;
            tgl_s3_reg <= 1'h0;
        end else if (ce_i) begin
            hiz_s1_reg <= hiz_t_reg;
            hiz_s2_reg <= hiz_s1_reg;
            q_hiz_o <= hiz_s2_reg; // RULE7 RULE10
            tgl_s1_reg <= upd_tgl_reg;
            tgl_s2_reg <= tgl_s1_reg;
            tgl_s3_reg <= tgl_s2_reg;
        end
    end

    // Drive word held until the FIFO accepts it; a new transfer while full replaces it
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_reg <= 1'h0;
            word_reg <= '0;
        end else if (ce_i) begin
            if (tgl_s2_reg != tgl_s3_reg && drv_en_reg) begin
                pend_reg <= 1'h1; // RULE11
                word_reg <= drv_reg;
            end else if (pend_reg && fifo_in_ready) begin
                pend_reg <= 1'h0;
            end
        end
    end

    // Drive-word buffer
    sbt_fifo #(
        .WIDTH(Q_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(pend_reg),
        .in_data_i(word_reg),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_out_valid),
        .out_data_o(fifo_out_data),
        .out_ready_i(fifo_out_ready)
    );

    // Output stage so the stream leaves from flip-flops
    assign fifo_out_ready = !q_test_valid_o || q_test_ready_i;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_test_valid_o <= 1'h0;
            q_test_o <= '0;
        end else if (ce_i && fifo_out_ready) begin
            q_test_valid_o <= fifo_out_valid;
            if (fifo_out_valid) begin
                q_test_o <= fifo_out_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_load_extest;
        en_t && state_reg == ST_UPD_IR && ir_sh_reg == IR_EXTEST;
    endsequence
    sequence s_five_tms;
        (en_t && tms_i)[*5];
    endsequence
    property p_tlr_force;
        @(posedge tck_i) disable iff (!rst_t_n)
        s_five_tms |=> state_reg == ST_TLR;
    endproperty
    a_tlr_force: assert property (p_tlr_force) // RULE18
        else $error("five TMS highs did not reach reset state");
    property p_ir_capture;
        @(posedge tck_i) disable iff (!rst_t_n)
        en_t && state_reg == ST_CAP_IR |=> ir_sh_reg == 3'h1;
    endproperty
    a_ir_capture: assert property (p_ir_capture) // RULE2
        else $error("instruction capture value wrong");
    property p_id_first;
        @(posedge tck_i) disable iff (!rst_t_n)
        en_t && state_reg == ST_CAP_DR && ir_reg == IR_IDCODE
            ##1 en_t && state_reg == ST_SH_DR |-> id_sh_reg[0] == 1'h1;
    endproperty
    a_id_first: assert property (p_id_first) // RULE19
        else $error("ID did not start with a one");
    property p_zsample_hiz;
        @(posedge tck_i) disable iff (!rst_t_n)
        en_t && state_reg == ST_UPD_IR && ir_sh_reg == IR_SAMPLEZ
            |=> hiz_t_reg;
    endproperty
    a_zsample_hiz: assert property (p_zsample_hiz) // RULE7
        else $error("output-off sampling left Q driven");
    property p_sample_drive;
        @(posedge tck_i) disable iff (!rst_t_n)
        en_t && state_reg == ST_UPD_IR && ir_sh_reg == IR_SAMPLE
            |=> !hiz_t_reg;
    endproperty
    a_sample_drive: assert property (p_sample_drive) // RULE8
        else $error("sampling floated Q");
    property p_byp_clear;
        @(posedge tck_i) disable iff (!rst_t_n)
        en_t && state_reg == ST_UPD_IR && ir_sh_reg == IR_BYPASS
            |=> byp_reg == 1'h0 && ir_reg == IR_BYPASS;
    endproperty
    a_byp_clear: assert property (p_byp_clear) // RULE9
        else $error("bypass cell not cleared");
    property p_extest_load;
        @(posedge tck_i) disable iff (!rst_t_n)
        s_load_extest |=> hiz_t_reg == !$past(ctrl_reg)
            && drv_reg == $past(bsr_reg[Q_LSB +: Q_W]);
    endproperty
    a_extest_load: assert property (p_extest_load) // RULE10 RULE11
        else $error("external test transfer wrong");
    property p_ctrl_lock;
        @(posedge tck_i) disable iff (!rst_t_n)
        !(ir_reg == IR_SAMPLE || ir_reg == IR_EXTEST) |=> $stable(ctrl_reg);
    endproperty
    a_ctrl_lock: assert property (p_ctrl_lock) // RULE12
        else $error("control cell changed outside allowed instructions");
    property p_tdi_enter;
        @(posedge tck_i) disable iff (!rst_t_n)
        en_t && sel_bsr && state_reg == ST_SH_DR
            |=> bsr_reg[CTRL_POS] == $past(tdi_i);
    endproperty
    a_tdi_enter: assert property (p_tdi_enter) // RULE13
        else $error("TDI did not enter the first cell");
    property p_word_push;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && pend_reg && fifo_in_ready
            && tgl_s2_reg == tgl_s3_reg |=> !pend_reg;
    endproperty
    a_word_push: assert property (p_word_push) // RULE11
        else $error("drive word not handed to buffer");
endmodule

// ---- sbt_jtag_ctl.sv ----
// Model of the external boundary-scan controller that drives the test port
`timescale 1ns/1ps
module sbt_jtag_ctl (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i
);
    // ------------------------------------------------------------
    // Idle pin levels; the test clock only runs inside the tasks
    // ------------------------------------------------------------
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One test clock period: pins change after the falling edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #16 tck_o = 1'b1;
        tdo = tdo_i;
        #16 tck_o = 1'b0;
    endtask

    // Hold mode select high, then park in run-test/idle
    task automatic to_reset(input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            step(1'b1, 1'b0, d);
        end
        step(1'b0, 1'b0, d);
    endtask

    // Full scan from idle back to idle, first bit out is bit 0
    task automatic scan(input logic is_ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic d;
        dout = '0;
        step(1'b1, 1'b0, d);
        if (is_ir) begin
            step(1'b1, 1'b0, d);
        end
        step(1'b0, 1'b0, d);
        step(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        step(1'b1, ~din[n - 1], d);
        step(1'b0, din[n - 1], d);
    endtask

    // Instruction load that never issues a reserved code
    task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
        logic [127:0] o;
        if (code inside {3'h3, 3'h5, 3'h6}) begin
            code = 3'h7;
        end
        scan(1'b1, 3, {125'h0, code}, o);
        cap = o[2:0];
    endtask
endmodule

// ---- sbt_tap_tb.sv ----
// Self-checking testbench for the boundary-scan test port
`timescale 1ns/1ps
module sbt_tap_tb;
    import sbt_pkg::*;
    logic clk_sys_i, rst_n_i, ce_i, tck, tms, tdi, tdo_o, tdo_oe_o;
    logic q_hiz_o, q_test_valid_o, q_test_ready_i;
    logic [107:0] pin_i;
    logic [35:0] q_test_o;
    int mismatches, total_checks, cycles;
    localparam logic [107:0] PINS_A = {9{12'hA5C}};
    localparam logic [107:0] PINS_B = {9{12'h3E1}};

    sbt_tap i_sbt_tap (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .pin_i(pin_i), .q_hiz_o(q_hiz_o), .q_test_o(q_test_o),
        .q_test_valid_o(q_test_valid_o), .q_test_ready_i(q_test_ready_i));
    // Released data out reads inverted, so a sample outside shifting fails
    sbt_jtag_ctl i_sbt_jtag_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .tdo_i(tdo_oe_o ? tdo_o : ~tdo_o));

    // System clock and hang guard
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_sys(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_idcode();
        logic [2:0] cap;
        logic [127:0] o;
        i_sbt_jtag_ctl.scan(1'b0, ID_W, 128'h0, o);
        check(o[31:0], ID_WORD);
        check({o[31:29], o[0]}, 4'h1);
        i_sbt_jtag_ctl.load_ir(IR_IDCODE, cap);
        check(cap, 3'h1);
        i_sbt_jtag_ctl.scan(1'b0, ID_W, 128'h0, o);
        check(o[31:0], ID_WORD);
        check(tdo_oe_o, 1'b0);
    endtask

    task automatic t_bypass();
        logic [2:0] cap;
        logic [127:0] o;
        i_sbt_jtag_ctl.load_ir(IR_BYPASS, cap);
        i_sbt_jtag_ctl.scan(1'b0, 8, 128'hB5, o);
        check(o[7:0], 8'h6A);
    endtask

    // Output-off sampling floats Q and must not alter the control cell
    task automatic t_samplez();
        logic [2:0] cap;
        logic [127:0] o;
        wait_sys(1);
        pin_i = PINS_A;
        i_sbt_jtag_ctl.load_ir(IR_SAMPLEZ, cap);
        wait_sys(8);
        check(q_hiz_o, 1'b1);
        i_sbt_jtag_ctl.scan(1'b0, BSR_LEN, {19'h0, 1'b1, 108'h0}, o);
        check(o[108:0], {1'b0, PINS_A});
        i_sbt_jtag_ctl.load_ir(IR_EXTEST, cap);
        wait_sys(8);
        check({q_hiz_o, q_test_valid_o}, 2'h2);
    endtask

    // Sampling sets the control cell, then external test fills the stream
    task automatic t_extest();
        logic [2:0] cap;
        logic [127:0] o;
        int n;
        wait_sys(1);
        pin_i = PINS_B;
        i_sbt_jtag_ctl.load_ir(IR_SAMPLE, cap);
        wait_sys(8);
        check(q_hiz_o, 1'b0);
        i_sbt_jtag_ctl.scan(1'b0, BSR_LEN, {19'h0, 1'b1, PINS_B}, o);
        check(o[108:0], {1'b0, PINS_B});
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            i_sbt_jtag_ctl.load_ir(IR_EXTEST, cap);
        end
        wait_sys(8);
        check({q_hiz_o, q_test_valid_o, q_test_o}, {2'h1, PINS_B[35:0]});
        q_test_ready_i = 1'b1;
        n = 0;
        repeat (40) begin
            if (q_test_valid_o === 1'b1 && q_test_o === PINS_B[35:0]) begin
                n++;
            end
            wait_sys(1);
        end
        check(n, 32);
        check(q_test_valid_o, 1'b0);
        i_sbt_jtag_ctl.scan(1'b0, BSR_LEN, 128'h0, o);
        check(o[108], 1'b1);
        i_sbt_jtag_ctl.load_ir(IR_EXTEST, cap);
        wait_sys(8);
        check({q_hiz_o, q_test_valid_o}, 2'h2);
    endtask

    // Mode select high alone returns the port to its reset state
    task automatic t_reset();
        logic [127:0] o;
        i_sbt_jtag_ctl.to_reset(5);
        wait_sys(8);
        check(q_hiz_o, 1'b0);
        i_sbt_jtag_ctl.scan(1'b0, ID_W, 128'h0, o);
        check(o[31:0], ID_WORD);
    endtask

    // Main sequence
    initial begin
        clk_sys_i = 1'b0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        pin_i = '0;
        q_test_ready_i = 1'b0;
        mismatches = 0;
        total_checks = 0;
        cycles = 0;
        // Six system edges in reset; one test clock edge clears the test side
        fork
            repeat (6) @(posedge clk_sys_i);
            i_sbt_jtag_ctl.to_reset(0);
        join
        #1;
        rst_n_i = 1'b1;
        i_sbt_jtag_ctl.to_reset(8);
        t_idcode();
        t_bypass();
        t_samplez();
        t_extest();
        t_reset();
        conclude();
    end
endmodule
